// *** pkg/linsf_regs.svh ***
// Purpose: register map, bit positions and reset values of the LIN flags
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   included by bare name; guarded against double inclusion
`ifndef LINSF_REGS_SVH
`define LINSF_REGS_SVH

// ****************************************************************
// Register addresses and widths
// ****************************************************************
`define LINSF_IE_ADDR   32'h4000_1820
`define LINSF_CLR_ADDR  32'h4000_1824
`define LINSF_STAT_ADDR 32'h4000_1828
`define LINSF_DATA_W    32
`define LINSF_FLAG_W    18
`define LINSF_FLAG_RST  18'h0_0000
`define LINSF_IE_RST    18'h0_0000

// ****************************************************************
// Flag bit positions, shared by status, clear and enable
// ****************************************************************
`define LINSF_B_RXBYTE   0
`define LINSF_B_TXBYTE   1
`define LINSF_B_BRKSYNC  2
`define LINSF_B_AUTOSYNC 3
`define LINSF_B_AUTOBAUD 4
`define LINSF_B_BUSIDLE  5
`define LINSF_B_WAKE     6
`define LINSF_B_PARITY   7
`define LINSF_B_BRKFLD   8
`define LINSF_B_BRKDEL   9
`define LINSF_B_SYNCFLD  10
`define LINSF_B_HGAP     11
`define LINSF_B_RXOVR    12
`define LINSF_B_RXFRM    13
`define LINSF_B_RXDAT    14
`define LINSF_B_TXOVR    15
`define LINSF_B_TXFRM    16
`define LINSF_B_TXDAT    17

`endif

// *** pkg/linsf_pkg.sv ***
// Purpose: shared types and the byte-lane helper of the LIN flag block
// Assumes: constants come from linsf_regs.svh
// Notes:   no timescale, definitions only
`include "linsf_regs.svh"
package linsf_pkg;
  typedef logic [`LINSF_FLAG_W-1:0]   linsf_flags_t;
  typedef logic [`LINSF_DATA_W-1:0]   linsf_word_t;
  typedef logic [`LINSF_DATA_W/8-1:0] linsf_strb_t;

  // Expand APB byte strobes into a bit mask
  function automatic linsf_word_t linsf_lane_mask(input linsf_strb_t strb);
    linsf_word_t m;
    m = '0;
    for (int i = 0; i < `LINSF_DATA_W / 8; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction
endpackage

// *** src/linsf_addr_decode.sv ***
// Purpose: decode the APB address into the three register hits
// Assumes: full 32-bit byte addresses, word aligned
// Notes:   purely combinational
`timescale 1ns/1ps
`include "linsf_regs.svh"
module linsf_addr_decode
  import linsf_pkg::*;
(
  // Bus address
  input  wire logic [`LINSF_DATA_W-1:0] paddr,
  // Register hits
  output logic                          hitIe,
  output logic                          hitClr,
  output logic                          hitStat
);
  // Exact word match; low address bits must be zero too
  function automatic logic addrMatch(input linsf_word_t a,
                                     input linsf_word_t reg_a);
    return a == reg_a;
  endfunction

  assign hitIe   = addrMatch(paddr, `LINSF_IE_ADDR);
  assign hitClr  = addrMatch(paddr, `LINSF_CLR_ADDR);
  assign hitStat = addrMatch(paddr, `LINSF_STAT_ADDR);
endmodule

// *** src/linsf_flag_bank.sv ***
// Purpose: sticky flag storage with set and write-one clear
// Assumes: set and clear requests are single-cycle, synchronous
// Notes:   set beats clear in the same cycle so no event is lost
`timescale 1ns/1ps
`include "linsf_regs.svh"
module linsf_flag_bank #(
  parameter int W = `LINSF_FLAG_W
) (
  // Clock and synchronised reset
  input  wire logic         sys_clk,
  input  wire logic         rstSyncN,
  // Set and clear requests
  input  wire logic [W-1:0] setVec,
  input  wire logic [W-1:0] clrVec,
  // Sticky flags
  output logic      [W-1:0] flagQ
);
  logic [W-1:0] flag_reg;
  logic [W-1:0] flag_next;

  if (W < 1 || W > `LINSF_DATA_W) begin : g_chk
    $error("flag width out of range");
  end

  // Clear only where asked, then let a new event win
  assign flag_next = (flag_reg & ~clrVec) | setVec;

  // Storage; the bus has no direct write path here
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      flag_reg <= W'(`LINSF_FLAG_RST);
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flagQ = flag_reg;
endmodule

// *** src/linsf_top.sv ***
// Purpose: LIN status flag register with clear and enable registers
// Assumes: event inputs are one-cycle pulses synchronous to sys_clk
// Notes:   APB slave answers with exactly one wait-free access cycle
`timescale 1ns/1ps
`include "linsf_regs.svh"
module linsf_top
  import linsf_pkg::*;
#(
  parameter int FLAG_W = `LINSF_FLAG_W
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`LINSF_DATA_W-1:0]   paddr,
  input  wire logic [`LINSF_DATA_W-1:0]   pwdata,
  input  wire logic [`LINSF_DATA_W/8-1:0] pstrb,
  output logic                            pready,
  output logic      [`LINSF_DATA_W-1:0]   prdata,
  output logic                            pslverr,
  // Frame events from the LIN controller
  input  wire logic                       rxByteDone,
  input  wire logic                       txByteDone,
  input  wire logic                       brkSyncDone,
  input  wire logic                       autobaudActive,
  input  wire logic                       autobaudDone,
  input  wire logic                       busIdle,
  input  wire logic                       wakeUp,
  // Header errors
  input  wire logic                       protectedIdentifierErr,
  input  wire logic                       brkFieldErr,
  input  wire logic                       brkDelimErr,
  input  wire logic                       syncFieldErr,
  input  wire logic                       headerGapErr,
  // Data path errors
  input  wire logic                       rxOverrun,
  input  wire logic                       rxFrameErr,
  input  wire logic                       rxDataErr,
  input  wire logic                       txOverrun,
  input  wire logic                       txFrameErr,
  input  wire logic                       txDataErr,
  // Interrupt request
  output logic                            lin_interrupt_line
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (FLAG_W != `LINSF_FLAG_W) begin : g_chk
    $error("FLAG_W must match the flag layout");
  end

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rstMeta_reg;
  logic rstSync_reg;
  logic rstSyncN;

  // Assert at once, release through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  assign rstSyncN = rstSync_reg;

  // ****************************************************************
  // Address decode and bus phases
  // ****************************************************************
  logic         hitIe;
  logic         hitClr;
  logic         hitStat;
  logic         setupPh;
  logic         accessDone;
  logic         wrDone;
  logic         hitAny;
  linsf_word_t  laneMask;

  linsf_addr_decode u_dec (
    .paddr   (paddr),
    .hitIe   (hitIe),
    .hitClr  (hitClr),
    .hitStat (hitStat)
  );

  // A write only lands at the edge that completes the access
  assign setupPh    = psel & ~penable;
  assign accessDone = psel & penable & pready;
  assign wrDone     = accessDone & pwrite;
  assign hitAny     = hitIe | hitClr | hitStat;
  assign laneMask   = linsf_lane_mask(pstrb);

  // ****************************************************************
  // Event gathering
  // ****************************************************************
  linsf_flags_t setVec;
  linsf_flags_t clrVec;
  linsf_flags_t flagQ;

  // One set line per flag position
  assign setVec[`LINSF_B_RXBYTE]   = rxByteDone;
  assign setVec[`LINSF_B_TXBYTE]   = txByteDone;
  assign setVec[`LINSF_B_BRKSYNC]  = brkSyncDone;
  assign setVec[`LINSF_B_AUTOSYNC] = brkSyncDone & autobaudActive;
  assign setVec[`LINSF_B_AUTOBAUD] = autobaudDone;
  assign setVec[`LINSF_B_BUSIDLE]  = busIdle;
  assign setVec[`LINSF_B_WAKE]     = wakeUp;
  assign setVec[`LINSF_B_PARITY]   = protectedIdentifierErr;
  assign setVec[`LINSF_B_BRKFLD]   = brkFieldErr;
  assign setVec[`LINSF_B_BRKDEL]   = brkDelimErr;
  assign setVec[`LINSF_B_SYNCFLD]  = syncFieldErr;
  assign setVec[`LINSF_B_HGAP]     = headerGapErr;
  assign setVec[`LINSF_B_RXOVR]    = rxOverrun;
  assign setVec[`LINSF_B_RXFRM]    = rxFrameErr;
  assign setVec[`LINSF_B_RXDAT]    = rxDataErr;
  assign setVec[`LINSF_B_TXOVR]    = txOverrun;
  assign setVec[`LINSF_B_TXFRM]    = txFrameErr;
  assign setVec[`LINSF_B_TXDAT]    = txDataErr;

  // Write-one clear; byte lanes not strobed clear nothing
  assign clrVec = (wrDone & hitClr)
                ? FLAG_W'(pwdata & laneMask) : '0;

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // Status writes are not routed here, so they cannot alter a flag
  linsf_flag_bank #(
    .W (FLAG_W)
  ) u_flags (
    .sys_clk  (sys_clk),
    .rstSyncN (rstSyncN),
    .setVec   (setVec),
    .clrVec   (clrVec),
    .flagQ    (flagQ)
  );

  // ****************************************************************
  // Interrupt enable register
  // ****************************************************************
  linsf_flags_t ie_reg;
  linsf_flags_t ie_next;
  linsf_flags_t ieMask;

  // Byte-lane merge of a write into the enable register
  assign ieMask  = FLAG_W'(laneMask);
  assign ie_next = (wrDone & hitIe)
                 ? (ie_reg & ~ieMask) | (FLAG_W'(pwdata) & ieMask)
                 : ie_reg;

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      ie_reg <= `LINSF_IE_RST;
    end else begin
      ie_reg <= ie_next;
    end
  end

  // ****************************************************************
  // Interrupt line
  // ****************************************************************
  logic irqCause;
  logic irq_reg;

  // Registered so the pin never glitches on decode
  assign irqCause = |(flagQ & ie_reg);

  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irqCause;
    end
  end
  assign lin_interrupt_line = irq_reg;

  // ****************************************************************
  // APB response
  // ****************************************************************
  logic        pready_reg;
  logic        pslverr_reg;
  linsf_word_t prdata_reg;
  linsf_word_t rd_next;

  // Clear register reads zero; unused upper bits read zero
  assign rd_next = (~pwrite & hitStat)
                 ? `LINSF_DATA_W'(flagQ)
                 : (~pwrite & hitIe) ? `LINSF_DATA_W'(ie_reg) : '0;

  // Answer is prepared in the setup cycle, shown in the access cycle
  always_ff @(posedge sys_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= setupPh;
      pslverr_reg <= setupPh & ~hitAny;
      if (setupPh) begin
        prdata_reg <= rd_next;
      end
    end
  end
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata  = prdata_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSyncN);

  logic [`LINSF_FLAG_W-1:0] clrOnly;
  assign clrOnly = clrVec & ~setVec;

  // ****************************************************************
  // Event capture
  // ****************************************************************
  // Every event shows in its flag at the next edge, never later
  a_rxbyte_set: assert property (
    rxByteDone |=> flagQ[`LINSF_B_RXBYTE])
    else $error("rx byte flag not set");
  a_txbyte_set: assert property (
    txByteDone |=> flagQ[`LINSF_B_TXBYTE])
    else $error("tx byte flag not set");
  a_brksync_set: assert property (
    brkSyncDone |=> flagQ[`LINSF_B_BRKSYNC])
    else $error("break sync flag not set");
  a_autosync_gate: assert property (
    (brkSyncDone && !autobaudActive && !flagQ[`LINSF_B_AUTOSYNC])
    |=> !flagQ[`LINSF_B_AUTOSYNC])
    else $error("autobaud sync flag set without autobaud");
  a_autosync_set: assert property (
    (brkSyncDone && autobaudActive) |=> flagQ[`LINSF_B_AUTOSYNC])
    else $error("autobaud sync flag not set");
  a_busidle_set: assert property (
    busIdle |=> flagQ[`LINSF_B_BUSIDLE])
    else $error("bus idle flag not set");
  a_wake_set: assert property (
    wakeUp |=> flagQ[`LINSF_B_WAKE])
    else $error("wake flag not set");
  a_parity_set: assert property (
    protectedIdentifierErr |=> flagQ[`LINSF_B_PARITY])
    else $error("parity flag not set");
  a_brkfld_set: assert property (
    brkFieldErr |=> flagQ[`LINSF_B_BRKFLD])
    else $error("break field flag not set");
  a_brkdel_set: assert property (
    brkDelimErr |=> flagQ[`LINSF_B_BRKDEL])
    else $error("break delimiter flag not set");
  a_syncfld_set: assert property (
    syncFieldErr |=> flagQ[`LINSF_B_SYNCFLD])
    else $error("sync field flag not set");
  a_hgap_set: assert property (
    headerGapErr |=> flagQ[`LINSF_B_HGAP])
    else $error("header gap flag not set");
  a_rxovr_set: assert property (
    rxOverrun |=> flagQ[`LINSF_B_RXOVR])
    else $error("rx overrun flag not set");
  a_rxfrm_set: assert property (
    rxFrameErr |=> flagQ[`LINSF_B_RXFRM])
    else $error("rx framing flag not set");
  a_rxdat_set: assert property (
    rxDataErr |=> flagQ[`LINSF_B_RXDAT])
    else $error("rx data flag not set");
  a_txovr_set: assert property (
    txOverrun |=> flagQ[`LINSF_B_TXOVR])
    else $error("tx overrun flag not set");
  a_txfrm_set: assert property (
    txFrameErr |=> flagQ[`LINSF_B_TXFRM])
    else $error("tx framing flag not set");
  a_txdat_set: assert property (
    txDataErr |=> flagQ[`LINSF_B_TXDAT])
    else $error("tx data flag not set");

  // ****************************************************************
  // Clear and read-only behaviour
  // ****************************************************************
  // A clear must not swallow an event that lands on the same edge
  a_clear_works: assert property (
    (|clrOnly) |=> ((flagQ & $past(clrOnly)) == '0))
    else $error("write-one clear did not clear");
  a_set_wins: assert property (
    (|(clrVec & setVec)) |=> ((flagQ & $past(setVec)) == $past(setVec)))
    else $error("clear beat a same-cycle event");
  a_flag_rise: assert property (
    (setVec == '0) |=> ((flagQ & ~$past(flagQ)) == '0))
    else $error("flag rose without an event");

  // ****************************************************************
  // Interrupt line
  // ****************************************************************
  // The enable register moves only on a completed bus write
  a_ie_hold: assert property (
    !(wrDone && hitIe) |=> $stable(ie_reg))
    else $error("enable register changed without a write");
  a_irq_follow: assert property (
    irqCause |=> lin_interrupt_line)
    else $error("enabled flag did not raise interrupt");
  a_irq_masked: assert property (
    !irqCause |=> !lin_interrupt_line)
    else $error("interrupt without enabled flag");

  // ****************************************************************
  // Autobaud flag, read data and bus answer
  // ****************************************************************
  // Read data is a snapshot taken at the setup edge
  a_autobaud_set: assert property (
    autobaudDone |=> flagQ[`LINSF_B_AUTOBAUD])
    else $error("autobaud flag not set");
  a_upper_zero: assert property (
    pready |-> (prdata[`LINSF_DATA_W-1:`LINSF_FLAG_W] == '0))
    else $error("unused status bits not zero");
  a_stat_ro: assert property (
    (wrDone && hitStat && setVec == '0) |=> $stable(flagQ))
    else $error("status write altered flags");
  a_apb_answer: assert property (
    setupPh |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");
  a_read_snap: assert property (
    (setupPh && !pwrite && hitStat)
    |=> (prdata == `LINSF_DATA_W'($past(flagQ))))
    else $error("status read data differs from flags");
  a_bad_addr: assert property (
    (setupPh && !hitAny) |=> (pready && pslverr))
    else $error("unmapped address not refused");
  a_good_addr: assert property (
    (setupPh && hitAny) |=> !pslverr)
    else $error("mapped address answered with error");

  // ****************************************************************
  // Covers
  // ****************************************************************
  // Main scenarios that the bench is expected to reach
  c_clear_write: cover property (wrDone && hitClr && |flagQ);
  c_irq_rise: cover property (!lin_interrupt_line ##1 lin_interrupt_line);
  c_set_clear: cover property (|(clrVec & setVec));
  c_bad_addr: cover property (pslverr && pready);
  c_autosync: cover property (brkSyncDone && autobaudActive);
endmodule

// *** test/linsf_event_model.sv ***
// Purpose: stand-in for the LIN controller that raises flag events
// Assumes: one-cycle pulses, launched just after a rising edge
// Notes:   bit 3 stands for break-sync done with autobaud active
`timescale 1ns/1ps
// ****************************************************************
// Event source on the controller side of the flag block
// ****************************************************************
module linsf_event_model
  import linsf_pkg::*;
(
  // Clock
  input  wire logic   sys_clk,
  // Event pulses, one bit per flag position
  output linsf_flags_t evVec
);
  // Lines rest low between events, as the controller keeps them
  initial evVec = '0;

  // Pulse the chosen events for exactly one cycle, so a stuck
  // level cannot hide a flag that fails to hold by itself
  task automatic fire(input linsf_flags_t m);
    @(posedge sys_clk);
    evVec <= m;
    @(posedge sys_clk);
    evVec <= '0;
  endtask
endmodule

// *** test/lin_status_flag_register_test.sv ***
// Purpose: self-checking bench for the LIN status flag block
// Assumes: APB slave answers within a few cycles, set by events, cleared by write-one
// Notes:   expected words are worked out from flag bit positions
`timescale 1ns/1ps
`include "linsf_regs.svh"
module lin_status_flag_register_test
  import linsf_pkg::*;
  ;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic         sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic         intLine, er;
  linsf_word_t  paddr, pwdata, prdata, rd;
  linsf_strb_t  pstrb;
  linsf_flags_t ev;
  linsf_word_t  flSet [18];
  linsf_word_t  flClr [18];
  int           n_mismatch, num_checks, cyc;

  // Event source on the far side
  linsf_event_model i_ev (.sys_clk(sys_clk), .evVec(ev));

  // Bit 3 is reached only through break-sync with autobaud active
  linsf_top i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rxByteDone(ev[0]), .txByteDone(ev[1]), .brkSyncDone(ev[2] | ev[3]),
    .autobaudActive(ev[3]), .autobaudDone(ev[4]), .busIdle(ev[5]),
    .wakeUp(ev[6]), .protectedIdentifierErr(ev[7]), .brkFieldErr(ev[8]),
    .brkDelimErr(ev[9]), .syncFieldErr(ev[10]), .headerGapErr(ev[11]),
    .rxOverrun(ev[12]), .rxFrameErr(ev[13]), .rxDataErr(ev[14]),
    .txOverrun(ev[15]), .txFrameErr(ev[16]), .txDataErr(ev[17]),
    .lin_interrupt_line(intLine));

  // Clock at 20 MHz
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  // ****************************************************************
  // Reporting and bus tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Word compare; case inequality so an unknown never matches
  task automatic chk(input linsf_word_t got, input linsf_word_t exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; starts a cycle after any previous release
  task automatic apb(input linsf_word_t a, input logic w,
                     input linsf_word_t d, input linsf_strb_t s);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the hang guard ends it
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input linsf_word_t a, input linsf_word_t d);
    apb(a, 1'b1, d, 4'hF);
  endtask

  task automatic rdchk(input linsf_word_t a, input linsf_word_t exp);
    apb(a, 1'b0, 32'h0000_0000, 4'h0);
    chk(rd, exp);
  endtask

  // Interrupt settles one edge after the edge that completes the write; checked after two
  task automatic irqchk(input logic e);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, intLine}, {31'h0, e});
  endtask

  // Bit 3 event also pulses break-sync, so bit 2 comes along
  function automatic linsf_word_t want(input int i);
    want = 32'h0000_0001 << i;
    if (i == 3) want = want | 32'h0000_0004;
  endfunction

  task automatic chk_rng(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      chk(flSet[i], want(i));
      chk(flClr[i], 32'h0000_0000);
    end
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdchk(`LINSF_STAT_ADDR, 32'h0000_0000);
    rdchk(`LINSF_IE_ADDR, 32'h0000_0000);
    // Each event alone, then cleared by its own write-one
    for (int i = 0; i < 18; i++) begin
      i_ev.fire(18'h0_0001 << i);
      rdchk(`LINSF_STAT_ADDR, want(i));
      flSet[i] = rd;
      wr(`LINSF_CLR_ADDR, want(i));
      rdchk(`LINSF_CLR_ADDR, 32'h0000_0000);
      apb(`LINSF_STAT_ADDR, 1'b0, 32'h0000_0000, 4'h0);
      flClr[i] = rd;
    end
    chk_rng(0, 2);
    chk_rng(3, 5);
    chk_rng(6, 8);
    chk_rng(9, 11);
    chk_rng(12, 14);
    chk_rng(15, 17);
    // Status writes, zero clears and unstrobed lanes change nothing
    i_ev.fire(18'h0_1000);
    wr(`LINSF_STAT_ADDR, 32'hFFFF_FFFF);
    chk({31'h0, er}, 32'h0000_0000);
    wr(`LINSF_CLR_ADDR, 32'h0000_0000);
    apb(`LINSF_CLR_ADDR, 1'b1, 32'h0000_1000, 4'hD);
    rdchk(`LINSF_STAT_ADDR, 32'h0000_1000);
    // Event and clear of bit 12 meet on the write's completing edge
    fork
      wr(`LINSF_CLR_ADDR, 32'h0000_1000);
      begin
        @(posedge sys_clk);
        i_ev.fire(18'h0_1000);
      end
    join
    rdchk(`LINSF_STAT_ADDR, 32'h0000_1000);
    // Interrupt follows flag and enable together
    irqchk(1'b0);
    wr(`LINSF_IE_ADDR, 32'h0000_0020);
    irqchk(1'b0);
    wr(`LINSF_IE_ADDR, 32'h0000_1000);
    rdchk(`LINSF_IE_ADDR, 32'h0000_1000);
    irqchk(1'b1);
    wr(`LINSF_IE_ADDR, 32'h0000_0000);
    irqchk(1'b0);
    wr(`LINSF_IE_ADDR, 32'h0003_FFFF);
    irqchk(1'b1);
    wr(`LINSF_CLR_ADDR, 32'h0000_1000);
    irqchk(1'b0);
    // Unmapped address answers with an error
    apb(32'h4000_1830, 1'b0, 32'h0000_0000, 4'h0);
    chk({31'h0, er}, 32'h0000_0001);
    // Reset in mid-run wipes flags and enables
    i_ev.fire(18'h0_0081);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdchk(`LINSF_STAT_ADDR, 32'h0000_0000);
    rdchk(`LINSF_IE_ADDR, 32'h0000_0000);
    irqchk(1'b0);
    report_and_stop();
  end
endmodule
